// >>> rtl/fsp_consts.svh
// constants of the frame pulse generator: register indices, field positions,
// reset values and clock rates
// assumes inclusion by bare name from the package and the top module
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH

// ************************************************
// register indices (byte address is four times the index)
// ************************************************
`define FSP_IDX_CONTROL 8'h18
`define FSP_IDX_HIGH_UPPER 8'h19
`define FSP_IDX_HIGH_LOWER 8'h1A
`define FSP_IDX_LOW_UPPER 8'h1B
`define FSP_IDX_LOW_LOWER 8'h1C
`define FSP_IDX_STATUS 8'h30

// ************************************************
// control register field positions
// ************************************************
`define FSP_CTL_SRC_MSB 7
`define FSP_CTL_SRC_LSB 4
`define FSP_CTL_ONE_SHOT 3
`define FSP_CTL_START_LEVEL 2
`define FSP_CTL_STYLE 1
`define FSP_CTL_RUN 0

// ************************************************
// reset values
// ************************************************
`define FSP_RST_CONTROL 8'h00
`define FSP_RST_COUNT 8'h00

// ************************************************
// clock rates
// ************************************************
`define FSP_SYS_CLK_HZ 125000000
`define FSP_REF_CLK_HZ 25000000
`define FSP_REF_DIV (`FSP_SYS_CLK_HZ / `FSP_REF_CLK_HZ)

`endif

// >>> rtl/fsp_pkg.sv
// types shared by the frame pulse generator
// assumes the constants header is on the include path
`default_nettype none

package fsp_pkg;
   `include "fsp_consts.svh"

   // ************************************************
   // generator phase states
   // ************************************************
   typedef enum logic [1:0] {
      FSP_IDLE = 2'b00,
      FSP_HIGH = 2'b01,
      FSP_LOW = 2'b10
   } fsp_state_t;

   // ************************************************
   // stored control fields
   // ************************************************
   typedef struct packed {
      logic [3:0] source_select;
      logic start_level;
      logic timing_style;
      logic run_enable;
   } fsp_ctrl_t;
endpackage

`default_nettype wire

// >>> rtl/fsp_top.sv
// frame pulse generator with a classic wishbone register slave
// assumes back-channel frame clocks and general pins are synchronous to clk_i
//
// Register access over Wishbone was decided locally.
`default_nettype none

`include "fsp_consts.svh"

// Overview of operation
// RULE1 - codes 0000/0001 tick from port frame clocks
// RULE2 - codes 01xx tick from 25 MHz reference
// RULE3 - codes 1000-1110 pass general pin 0-6
// RULE4 - writing one-shot bit gives exactly one pulse
// RULE5 - one-shot bit clears itself, reads zero
// RULE6 - software waits pulse length before next request
// RULE7 - software keeps run enable low for one-shot
// RULE8 - generated signal starts at start level bit
// RULE9 - style 0 uses separate high, low counts
// RULE10 - style 1 uses one 24-bit count both phases
// RULE11 - high phase lasts count plus one tick
// RULE12 - low phase lasts count plus one tick
// RULE13 - high count from upper 0x19, lower 0x1A
// RULE14 - low count from upper 0x1B, lower 0x1C
// RULE15 - run enable alternates phases from start level
// RULE16 - idle generator holds start level
module fsp_top
   import fsp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic bc_frame_clk0_i,
   input wire logic bc_frame_clk1_i,
   input wire logic [6:0] gpio_i,
   output logic frame_pulse_o
);

   // ************************************************
   // functions
   // ************************************************

   // length of a phase minus one, in ticks
   function automatic logic [23:0] phase_len(input logic style, input logic is_high,
                                             input logic [15:0] hi, input logic [15:0] lo);
      logic [23:0] r;
      r = 24'h000000;
      if (style) begin
         r = {hi[7:0], lo}; // RULE10
      end else if (is_high) begin
         r = {8'h00, hi}; // RULE9
      end else begin
         r = {8'h00, lo}; // RULE9
      end
      return r;
   endfunction

   // word index of a byte address, or an unmapped marker
   function automatic logic [7:0] word_index(input logic [7:0] adr);
      logic [7:0] r;
      r = {2'b00, adr[7:2]};
      if (adr[1:0] != 2'b00) begin
         r = 8'hFF;
      end
      return r;
   endfunction

   // ************************************************
   // declarations
   // ************************************************
   fsp_ctrl_t ctrl_q;
   logic [7:0] high_upper_q;
   logic [7:0] high_lower_q;
   logic [7:0] low_upper_q;
   logic [7:0] low_lower_q;
   logic ack_q;
   logic [31:0] rdata_q;
   logic bc0_q;
   logic bc1_q;
   logic [2:0] ref_div_q;
   logic ref_tick_q;
   logic tick;
   fsp_state_t state_q;
   logic [23:0] count_q;
   logic one_shot_q;
   logic pulse_q;
   logic [15:0] high_phase_count;
   logic [15:0] low_phase_count;
   logic bus_req;
   logic bus_wr;
   logic [7:0] bus_idx;
   logic one_shot_request;
   logic [23:0] cur_len;
   logic gen_level;
   logic wr_ctrl;
   logic wr_high_upper;
   logic wr_high_lower;
   logic wr_low_upper;
   logic wr_low_lower;

   // ************************************************
   // bus decode
   // ************************************************

   // new request taken only when no ack is outstanding
   assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
   assign bus_wr = wb_cyc_i & wb_stb_i & ack_q & wb_we_i & wb_sel_i[0]; // lands at the edge the master sees ack
   assign bus_idx = word_index(wb_adr_i);
   assign one_shot_request = wr_ctrl & wb_dat_i[`FSP_CTL_ONE_SHOT];

   // one write strobe per writable register; status and unmapped words write nothing
   always_comb begin
      wr_ctrl = 1'b0;
      wr_high_upper = 1'b0;
      wr_high_lower = 1'b0;
      wr_low_upper = 1'b0;
      wr_low_lower = 1'b0;
      if (bus_wr) begin
         unique case (bus_idx)
            `FSP_IDX_CONTROL: wr_ctrl = 1'b1;
            `FSP_IDX_HIGH_UPPER: wr_high_upper = 1'b1;
            `FSP_IDX_HIGH_LOWER: wr_high_lower = 1'b1;
            `FSP_IDX_LOW_UPPER: wr_low_upper = 1'b1;
            `FSP_IDX_LOW_LOWER: wr_low_lower = 1'b1;
            default: begin
               wr_ctrl = 1'b0;
            end
         endcase
      end
   end

   // joined phase counts
   assign high_phase_count = {high_upper_q, high_lower_q}; // RULE13
   assign low_phase_count = {low_upper_q, low_lower_q}; // RULE14

   // ************************************************
   // register file
   // ************************************************

   // control register; the one-shot bit is not stored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= fsp_ctrl_t'(7'h00);
      end else if (wr_ctrl) begin
         ctrl_q.source_select <= wb_dat_i[`FSP_CTL_SRC_MSB:`FSP_CTL_SRC_LSB];
         ctrl_q.start_level <= wb_dat_i[`FSP_CTL_START_LEVEL];
         ctrl_q.timing_style <= wb_dat_i[`FSP_CTL_STYLE];
         ctrl_q.run_enable <= wb_dat_i[`FSP_CTL_RUN];
      end
   end

   // count registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         high_upper_q <= `FSP_RST_COUNT;
         high_lower_q <= `FSP_RST_COUNT;
         low_upper_q <= `FSP_RST_COUNT;
         low_lower_q <= `FSP_RST_COUNT;
      end else begin
         if (wr_high_upper) begin
            high_upper_q <= wb_dat_i[7:0];
         end
         if (wr_high_lower) begin
            high_lower_q <= wb_dat_i[7:0];
         end
         if (wr_low_upper) begin
            low_upper_q <= wb_dat_i[7:0];
         end
         if (wr_low_lower) begin
            low_lower_q <= wb_dat_i[7:0];
         end
      end
   end

   // acknowledge: one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= bus_req;
      end
   end

   // read data; unmapped words read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= 32'h00000000;
      end else if (bus_req) begin
         unique case (bus_idx)
            `FSP_IDX_CONTROL: begin
               rdata_q <= {24'h000000, ctrl_q.source_select, 1'b0, ctrl_q.start_level,
                           ctrl_q.timing_style, ctrl_q.run_enable}; // RULE5
            end
            `FSP_IDX_HIGH_UPPER: begin
               rdata_q <= {24'h000000, high_upper_q};
            end
            `FSP_IDX_HIGH_LOWER: begin
               rdata_q <= {24'h000000, high_lower_q};
            end
            `FSP_IDX_LOW_UPPER: begin
               rdata_q <= {24'h000000, low_upper_q};
            end
            `FSP_IDX_LOW_LOWER: begin
               rdata_q <= {24'h000000, low_lower_q};
            end
            `FSP_IDX_STATUS: begin
               rdata_q <= {28'h0000000, state_q, one_shot_q, pulse_q};
            end
            default: begin
               rdata_q <= 32'h00000000;
            end
         endcase
      end
   end

   // ************************************************
   // tick sources
   // ************************************************

   // previous levels of the back-channel frame clocks
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bc0_q <= 1'b0;
         bc1_q <= 1'b0;
      end else begin
         bc0_q <= bc_frame_clk0_i;
         bc1_q <= bc_frame_clk1_i;
      end
   end

   // 25 MHz reference enable from the system clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_div_q <= 3'h0;
         ref_tick_q <= 1'b0;
      end else if (ref_div_q == 3'(`FSP_REF_DIV - 1)) begin
         ref_div_q <= 3'h0;
         ref_tick_q <= 1'b1;
      end else begin
         ref_div_q <= ref_div_q + 3'h1;
         ref_tick_q <= 1'b0;
      end
   end

   // tick select; reserved codes give no tick
   always_comb begin
      tick = 1'b0;
      if (ctrl_q.source_select == 4'h0) begin
         tick = bc_frame_clk0_i & ~bc0_q; // RULE1
      end else if (ctrl_q.source_select == 4'h1) begin
         tick = bc_frame_clk1_i & ~bc1_q; // RULE1
      end else if (ctrl_q.source_select[3:2] == 2'b01) begin
         tick = ref_tick_q; // RULE2
      end
   end

   // ************************************************
   // phase generator
   // ************************************************

   // length of the phase now running
   assign cur_len = phase_len(ctrl_q.timing_style, state_q == FSP_HIGH, high_phase_count, low_phase_count);

   // phase state, tick count and one-shot flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= FSP_IDLE;
         count_q <= 24'h000000;
         one_shot_q <= 1'b0;
      end else begin
         unique case (state_q)
            FSP_IDLE: begin
               count_q <= 24'h000000;
               if (one_shot_request && !ctrl_q.run_enable) begin
                  // pulse is the phase opposite the start level
                  one_shot_q <= 1'b1; // RULE4
                  state_q <= ctrl_q.start_level ? FSP_LOW : FSP_HIGH; // RULE4
               end else if (ctrl_q.run_enable) begin
                  state_q <= ctrl_q.start_level ? FSP_HIGH : FSP_LOW; // RULE15
               end
            end
            FSP_HIGH, FSP_LOW: begin
               if (!one_shot_q && !ctrl_q.run_enable) begin
                  state_q <= FSP_IDLE; // RULE16
                  count_q <= 24'h000000;
               end else if (tick) begin
                  if (count_q >= cur_len) begin
                     // phase ends after count plus one ticks; a count lowered mid-phase cannot wrap
                     count_q <= 24'h000000; // RULE11 RULE12
                     if (one_shot_q) begin
                        one_shot_q <= 1'b0;
                        state_q <= FSP_IDLE;
                     end else begin
                        state_q <= (state_q == FSP_HIGH) ? FSP_LOW : FSP_HIGH; // RULE15
                     end
                  end else begin
                     count_q <= count_q + 24'h000001;
                  end
               end
            end
            default: begin
               state_q <= FSP_IDLE;
               count_q <= 24'h000000;
               one_shot_q <= 1'b0;
            end
         endcase
      end
   end

   // generated level; idle shows the start level
   always_comb begin
      gen_level = ctrl_q.start_level; // RULE8 RULE16
      if (state_q == FSP_HIGH) begin
         gen_level = 1'b1;
      end else if (state_q == FSP_LOW) begin
         gen_level = 1'b0;
      end
   end

   // output select: external pin, start level for code 1111, or generator
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pulse_q <= 1'b0;
      end else if (ctrl_q.source_select[3]) begin
         if (ctrl_q.source_select[2:0] != 3'h7) begin
            pulse_q <= gpio_i[ctrl_q.source_select[2:0]]; // RULE3
         end else begin
            pulse_q <= ctrl_q.start_level;
         end
      end else begin
         pulse_q <= gen_level;
      end
   end

   // ************************************************
   // outputs
   // ************************************************
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;
   assign frame_pulse_o = pulse_q;

endmodule

`default_nettype wire

// >>> sim/fsp_top_assertions.sv
// port checker for the frame pulse generator
// assumes it is bound onto fsp_top, one clock domain
`default_nettype none

module fsp_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [6:0] gpio_i,
   input wire logic frame_pulse_o
);
   logic [7:0] ctl_q;
   logic pin_q;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // shadow of the control byte and of the selected pin
   always_ff @(posedge clk_i) begin
      if (rst_i)
         ctl_q <= 8'h00;
      else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && wb_adr_i == 8'h60)
         ctl_q <= wb_dat_i[7:0];
      pin_q <= gpio_i[ctl_q[6:4]];
   end
   a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
      else $error("ack without request");
   a_oneshot_zero: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 8'h60 |-> !wb_dat_o[3])
      else $error("one-shot bit reads one");
   a_pin_follow: assert property (ctl_q[7] && ctl_q[6:4] != 3'h7 |=> frame_pulse_o == pin_q)
      else $error("pulse does not follow pin");
   a_reserved_level: assert property (ctl_q[7:4] == 4'hF |=> frame_pulse_o == $past(ctl_q[2]))
      else $error("reserved code not at start level");
   a_idle_level: assert property (!ctl_q[7] && $fell(ctl_q[0]) |=> ##1 frame_pulse_o == ctl_q[2])
      else $error("stopped generator not at start level");
   a_run_start: assert property (ctl_q[7:6] == 2'b01 && $rose(ctl_q[0]) |-> ##2 frame_pulse_o == ctl_q[2])
      else $error("run does not begin at start level");
endmodule

bind fsp_top fsp_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
   .wb_dat_i, .wb_dat_o, .wb_ack_o, .gpio_i, .frame_pulse_o);

`default_nettype wire

// >>> sim/fsp_top_tb.sv
// self-checking bench for the frame pulse generator
// assumes the design and checker are compiled before it
`default_nettype none

module fsp_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [31:0] rd_q;
   logic ack;
   logic pulse;
   logic p_q = 1'b0;
   logic bc0 = 1'b0;
   logic bc1 = 1'b0;
   logic [6:0] gpio = 7'h00;
   logic [3:0] ph = 4'h0;
   int err_total = 0;
   int checks_done = 0;
   int hi, lo, e, rises, hic;

   fsp_top u_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .bc_frame_clk0_i(bc0),
      .bc_frame_clk1_i(bc1), .gpio_i(gpio), .frame_pulse_o(pulse));

   // 125 MHz clock
   always #4 clk_i = ~clk_i;

   // port frame clocks, period 4 on port 0 and 6 on port 1
   always @(posedge clk_i) begin
      ph <= (ph == 4'hB) ? 4'h0 : ph + 4'h1;
      bc0 <= ph[1];
      bc1 <= (ph % 4'h6) < 4'h3;
   end

   // counts pulse rises and high cycles
   always @(posedge clk_i) begin
      p_q <= pulse;
      if (pulse === 1'b1 && p_q === 1'b0)
         rises++;
      if (pulse === 1'b1)
         hic++;
   end

   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      rd_q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] x, input string nm);
      bus(1'b0, a, 8'h00);
      chk(nm, rd_q, {24'h0, x});
   endtask

   // lengths of one whole high phase and the low phase after it; the partial first phase is skipped
   task automatic meas;
      hi = 0;
      lo = 0;
      repeat (2) @(posedge clk_i);
      while (pulse === 1'b1) @(posedge clk_i);
      while (pulse !== 1'b1) @(posedge clk_i);
      while (pulse === 1'b1) begin
         hi++;
         @(posedge clk_i);
      end
      while (pulse !== 1'b1) begin
         lo++;
         @(posedge clk_i);
      end
   endtask

   // stop, load the four count bytes, start, measure
   task automatic run(input logic [7:0] c, input logic [31:0] v, input int eh, input int el);
      bus(1'b1, 8'h60, 8'h00);
      for (int i = 0; i < 4; i++)
         bus(1'b1, 8'h64 + 8'(4 * i), v[31 - 8 * i -: 8]);
      bus(1'b1, 8'h60, c);
      meas;
      chk("high phase", hi, eh);
      chk("low phase", lo, el);
   endtask

   task automatic end_of_test;
      if (err_total == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("pulse after reset", pulse, 1'b0);
      for (int i = 0; i < 5; i++)
         rd(8'h60 + 8'(4 * i), 8'h00, "reset value");
      for (int i = 1; i < 5; i++) begin
         bus(1'b1, 8'h60 + 8'(4 * i), 8'hA0 + 8'(i));
         rd(8'h60 + 8'(4 * i), 8'hA0 + 8'(i), "count byte");
      end
      bus(1'b1, 8'h74, 8'h55);
      rd(8'h74, 8'h00, "unmapped");
      run(8'h41, 32'h0100_0003, 1285, 20);
      run(8'h41, 32'h0000_0102, 5, 1295);
      for (int i = 5; i < 8; i++)
         run({4'(i), 4'h1}, 32'h0001_0001, 10, 10);
      run(8'h47, 32'hFF00_0004, 25, 25);
      run(8'h01, 32'h0001_0000, 8, 4);
      run(8'h11, 32'h0001_0000, 12, 6);
      for (int c = 2; c < 4; c++) begin
         bus(1'b1, 8'h60, 8'h00);
         bus(1'b1, 8'h60, {4'(c), 4'h1});
         e = 0;
         repeat (40) begin
            @(posedge clk_i);
            e += int'(pulse !== 1'b0);
         end
         chk("reserved code", e, 0);
      end
      bus(1'b1, 8'h60, 8'h44);
      repeat (3) @(posedge clk_i);
      chk("idle level", pulse, 1'b1);
      rd(8'hC0, 8'h01, "status idle");
      bus(1'b1, 8'h60, 8'h40);
      bus(1'b1, 8'h64, 8'h00);
      bus(1'b1, 8'h68, 8'h01);
      repeat (2) begin
         rises = 0;
         hic = 0;
         bus(1'b1, 8'h60, 8'h48);
         rd(8'h60, 8'h40, "one-shot bit");
         repeat (60) @(posedge clk_i);
         chk("pulse count", rises, 1);
         chk("pulse width", hic >= 6 && hic <= 10, 1'b1);
      end
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, 8'h60, {1'b1, 3'(i), 4'h0});
         gpio <= 7'(1 << i);
         repeat (3) @(posedge clk_i);
         chk("pin high", pulse, 1'b1);
         gpio <= ~7'(1 << i);
         repeat (3) @(posedge clk_i);
         chk("pin low", pulse, 1'b0);
      end
      bus(1'b1, 8'h60, 8'hF4);
      repeat (3) @(posedge clk_i);
      chk("reserved pin code", pulse, 1'b1);
      end_of_test;
   end

   // watchdog against a hang
   initial begin
      repeat (30000) @(posedge clk_i);
      err_total++;
      end_of_test;
   end
endmodule

`default_nettype wire
